//--- shared/pmbp_defines.vh
// Purpose: constants for the program memory block protection logic
// Assumes: 22-bit table address space, byte-wide configuration bytes
// Notes: offsets are byte addresses in the table address space
`ifndef PMBP_DEFINES_VH
`define PMBP_DEFINES_VH

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define PMBP_ADDR_W 22
`define PMBP_BOOT_END 22'h0007ff
`define PMBP_BLK0_END 22'h003fff
`define PMBP_BLK1_END 22'h007fff
`define PMBP_BLK2_END 22'h00bfff
`define PMBP_BLK3_END 22'h00ffff
`define PMBP_BLK_SEL_HI 15
`define PMBP_BLK_SEL_LO 14
`define PMBP_ID_FIRST 22'h200000
`define PMBP_ID_LAST 22'h200007
`define PMBP_ID_COUNT 8
`define PMBP_DEVID_LO 22'h3ffffe
`define PMBP_DEVID_HI 22'h3fffff

// ----------------------------------------------------------------------
// protection configuration bytes
// ----------------------------------------------------------------------
`define PMBP_CFG_EXT_LOCK 22'h300008
`define PMBP_CFG_BOOT_EE_EXT 22'h300009
`define PMBP_CFG_TW_LOCK 22'h30000a
`define PMBP_CFG_BOOT_EE_CW 22'h30000b
`define PMBP_CFG_XR_LOCK 22'h30000c
`define PMBP_CFG_BOOT_XR 22'h30000d
`define PMBP_CFG_FIRST 22'h300008
`define PMBP_CFG_LAST 22'h30000d

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define PMBP_BIT_EE_EXT 7
`define PMBP_BIT_BOOT_EXT 6
`define PMBP_BIT_EE_WR 7
`define PMBP_BIT_BOOT_TW 6
`define PMBP_BIT_CFG_WR 5
`define PMBP_BIT_BOOT_XR 6

// ----------------------------------------------------------------------
// erased value of every protection bit; number of numbered blocks
// ----------------------------------------------------------------------
`define PMBP_ERASED 8'hff
`define PMBP_BLKS 4

`endif

//--- hdl/pmbp_block_decode.v
// Purpose: map a table address onto a protection block index
// Assumes: addresses in user program memory are below 0x010000
// Notes: index 4 stands for the boot block
`timescale 1ns/1ns
`include "pmbp_defines.vh"

module pmbp_block_decode (
  input wire [`PMBP_ADDR_W-1:0] addr_in,
  output wire in_prog_out,
  output wire [2:0] blk_out
);

  // ----------------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------------
  // bits 15:14 pick the block; below 0x800 it is the boot block
  assign in_prog_out = (addr_in <= `PMBP_BLK3_END);
  assign blk_out = (addr_in <= `PMBP_BOOT_END) ? 3'h4 :
    {1'b0, addr_in[`PMBP_BLK_SEL_HI:`PMBP_BLK_SEL_LO]};

endmodule // pmbp_block_decode

//--- hdl/pmbp_protect.v
// Purpose: block protection of program memory, data eeprom and config bytes; the id bytes are held here unprotected
// Assumes: core and programmer requests are single-cycle strobes on clk_in
// Notes: protection bits only clear by write; erase from the programmer sets them
//        lock bits keep no reset, so a fresh part must be chip erased before use

`timescale 1ns/1ns
`include "pmbp_defines.vh"

// Operation
// - program memory is four 16 Kbyte blocks; lowest split into boot and block zero
// - boot ends 0007ff, blocks end 003fff, 007fff, 00bfff, 00ffff
// - each block including boot has external, table-write and cross-read locks
// - external lock ignored for core; refuses programmer reads and writes of block
// - table writes to a block with table-write lock zero are blocked
// - table read from inside the same block returns true data
// - cross-block table read into read-locked block returns zeros
// - protection bits can be written only from one to zero
// - only programmer erase, chip or block, returns protection bits to one
// - eeprom external lock refuses programmer reads and writes of eeprom
// - eeprom write lock refuses programmer writes only
// - core may always read data eeprom
// - config write lock protects config bytes; core cannot change it
// - table reads return the device id; table access reaches config bytes
// - table access can address any program location, subject to locks
// - eight id bytes at 200000 to 200007, table read and write reachable
// - id bytes stay readable under code protection
// - on 48 Kbyte variant top block and its locks are absent, read zero
module pmbp_protect #(
  parameter HAS_TOP_BLOCK = 1,
  parameter [7:0] DEVID_LO = 8'h5a, // arbitrary value
  parameter [7:0] DEVID_HI = 8'ha5 // arbitrary value
) (
  input wire clk_in,
  input wire arst_n_in,
  // core table port
  input wire core_rd_in,
  input wire core_wr_in,
  input wire [`PMBP_ADDR_W-1:0] core_addr_in,
  input wire [`PMBP_ADDR_W-1:0] core_pc_in,
  input wire [7:0] core_wdata_in,
  input wire [7:0] mem_rdata_in,
  input wire core_ee_rd_in,
  output reg [7:0] core_rdata_out,
  output reg core_rvalid_out,
  output reg core_ee_rd_ok_out,
  // programmer port
  input wire prog_rd_in,
  input wire prog_wr_in,
  input wire prog_ee_in,
  input wire [`PMBP_ADDR_W-1:0] prog_addr_in,
  input wire [7:0] prog_wdata_in,
  input wire prog_chip_erase_in,
  input wire prog_blk_erase_in,
  input wire [2:0] prog_blk_sel_in,
  output reg [7:0] prog_rdata_out,
  output reg prog_rvalid_out,
  output reg prog_refused_out,
  // memory array strobes
  output reg mem_wr_out,
  output reg [`PMBP_ADDR_W-1:0] mem_addr_out,
  output reg [7:0] mem_wdata_out,
  output reg core_denied_out
);

  // ----------------------------------------------------------------------
  // protection state
  // ----------------------------------------------------------------------
  // index 0..3 are numbered blocks, index 4 is the boot block
  // three separate locks per block, so each kind of access is judged alone
  reg [4:0] ext_lock_q;
  reg [4:0] tw_lock_q;
  reg [4:0] xr_lock_q;
  reg ee_ext_lock_q;
  reg ee_wr_lock_q;
  reg cfg_wr_lock_q;
  reg [7:0] id_mem_q [0:`PMBP_ID_COUNT-1];

  wire [4:0] impl_mask = (HAS_TOP_BLOCK != 0) ? 5'h1f : 5'h17;

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire tgt_prog;
  wire [2:0] tgt_blk;
  wire pc_prog;
  wire [2:0] pc_blk;
  wire prg_prog;
  wire [2:0] prg_blk;

  // three decoders: table target, executing instruction and programmer address
  pmbp_block_decode u_tgt (
    .addr_in(core_addr_in),
    .in_prog_out(tgt_prog),
    .blk_out(tgt_blk)
  );

  pmbp_block_decode u_pc (
    .addr_in(core_pc_in),
    .in_prog_out(pc_prog),
    .blk_out(pc_blk)
  );

  pmbp_block_decode u_prg (
    .addr_in(prog_addr_in),
    .in_prog_out(prg_prog),
    .blk_out(prg_blk)
  );

  wire core_is_id = (core_addr_in >= `PMBP_ID_FIRST) && (core_addr_in <= `PMBP_ID_LAST);
  wire core_is_cfg = (core_addr_in >= `PMBP_CFG_FIRST) && (core_addr_in <= `PMBP_CFG_LAST);
  wire prog_is_id = (prog_addr_in >= `PMBP_ID_FIRST) && (prog_addr_in <= `PMBP_ID_LAST);
  wire prog_is_cfg = (prog_addr_in >= `PMBP_CFG_FIRST) && (prog_addr_in <= `PMBP_CFG_LAST);
  wire tgt_impl = tgt_prog && impl_mask[tgt_blk];
  wire prg_impl = prg_prog && impl_mask[prg_blk];

  // ----------------------------------------------------------------------
  // configuration byte read view
  // ----------------------------------------------------------------------
  // unimplemented bits read zero; absent top block locks read zero
  // core and programmer share this view, so both see the same masking
  function [7:0] cfg_view;
    input [`PMBP_ADDR_W-1:0] a;
    begin
      case (a)
        `PMBP_CFG_EXT_LOCK: cfg_view = {4'h0, ext_lock_q[3:0] & impl_mask[3:0]};
        `PMBP_CFG_BOOT_EE_EXT: cfg_view = {ee_ext_lock_q, ext_lock_q[4], 6'h00};
        `PMBP_CFG_TW_LOCK: cfg_view = {4'h0, tw_lock_q[3:0] & impl_mask[3:0]};
        `PMBP_CFG_BOOT_EE_CW: cfg_view = {ee_wr_lock_q, tw_lock_q[4], cfg_wr_lock_q, 5'h00};
        `PMBP_CFG_XR_LOCK: cfg_view = {4'h0, xr_lock_q[3:0] & impl_mask[3:0]};
        `PMBP_CFG_BOOT_XR: cfg_view = {1'b0, xr_lock_q[4], 6'h00};
        default: cfg_view = 8'h00;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // core access checks
  // ----------------------------------------------------------------------
  // a cross-block read into a read-locked block is denied
  wire core_xr_deny = tgt_impl && !xr_lock_q[tgt_blk] &&
    !(pc_prog && (pc_blk == tgt_blk));
  // table writes to write-locked blocks are dropped
  wire core_tw_deny = tgt_prog && !tw_lock_q[tgt_blk];
  // config bytes guarded by the config write lock
  wire core_cfg_deny = core_is_cfg && !cfg_wr_lock_q;
  // id bytes take table writes whatever the block locks say
  wire core_wr_ok = core_wr_in && ((tgt_impl && !core_tw_deny) || core_is_id) &&
    !core_cfg_deny;

  // ----------------------------------------------------------------------
  // programmer access checks
  // ----------------------------------------------------------------------
  // external locks bind the programmer only; the core never sees them
  // an eeprom access is judged by the eeprom locks only, not by the block its address hits
  wire prog_blk_deny = prg_impl && !prog_ee_in && !ext_lock_q[prg_blk];
  wire prog_ee_rd_deny = prog_ee_in && !ee_ext_lock_q;
  wire prog_ee_wr_deny = prog_ee_in && (!ee_ext_lock_q || !ee_wr_lock_q);
  // the config write lock shields the config bytes from the programmer as well
  wire prog_cfg_wr_deny = prog_is_cfg && !cfg_wr_lock_q;
  // both kinds of refusal feed the one registered flag
  wire prog_rd_deny = prog_rd_in && (prog_blk_deny || prog_ee_rd_deny);
  wire prog_wr_deny = prog_wr_in && (prog_blk_deny || prog_ee_wr_deny || prog_cfg_wr_deny);
  wire prog_wr_ok = prog_wr_in && !prog_wr_deny && !prog_ee_in && (prg_impl || prog_is_id);

  // ----------------------------------------------------------------------
  // read data muxes
  // ----------------------------------------------------------------------
  // id, config and device id bytes lie outside the block map, so no lock gates them
  reg [7:0] core_rd_d;
  always @* begin
    core_rd_d = 8'h00;
    if (core_is_id) begin
      core_rd_d = id_mem_q[core_addr_in[2:0]];
    end else if (core_is_cfg) begin
      core_rd_d = cfg_view(core_addr_in);
    end else if (core_addr_in == `PMBP_DEVID_LO) begin
      core_rd_d = DEVID_LO;
    end else if (core_addr_in == `PMBP_DEVID_HI) begin
      core_rd_d = DEVID_HI;
    end else if (tgt_impl && !core_xr_deny) begin
      core_rd_d = mem_rdata_in;
    end
  end

  // eeprom data bypasses this block; for the eeprom only the refusal is reported
  reg [7:0] prog_rd_d;
  always @* begin
    prog_rd_d = 8'h00;
    if (prog_rd_deny || prog_ee_in) begin
      prog_rd_d = 8'h00;
    end else if (prog_is_id) begin
      prog_rd_d = id_mem_q[prog_addr_in[2:0]];
    end else if (prog_is_cfg) begin
      prog_rd_d = cfg_view(prog_addr_in);
    end else if (prg_impl) begin
      prog_rd_d = mem_rdata_in;
    end
  end

  // ----------------------------------------------------------------------
  // protection bit update
  // ----------------------------------------------------------------------
  // writes can only clear (and); only programmer erase sets bits again
  wire cfg_wr = (core_wr_in && core_is_cfg && !core_cfg_deny) ||
    (prog_wr_in && prog_is_cfg && !prog_cfg_wr_deny);
  // one config byte write per cycle; the programmer takes precedence
  wire [`PMBP_ADDR_W-1:0] cfg_addr = (prog_wr_in && prog_is_cfg) ? prog_addr_in : core_addr_in;
  wire [7:0] cfg_data = (prog_wr_in && prog_is_cfg) ? prog_wdata_in : core_wdata_in;
  // the config write lock may be cleared only from the programmer
  wire cfg_wr_from_prog = prog_wr_in && prog_is_cfg;

  // no reset here: a reset must never unlock the part, only an erase may
  // hazard: the locks are unknown until the first chip erase of a fresh part
  always @(posedge clk_in) begin
    if (prog_chip_erase_in) begin
      ext_lock_q <= 5'h1f;
      tw_lock_q <= 5'h1f;
      xr_lock_q <= 5'h1f;
      ee_ext_lock_q <= 1'b1;
      ee_wr_lock_q <= 1'b1;
      cfg_wr_lock_q <= 1'b1;
    end else if (prog_blk_erase_in) begin
      ext_lock_q[prog_blk_sel_in] <= 1'b1;
      tw_lock_q[prog_blk_sel_in] <= 1'b1;
      xr_lock_q[prog_blk_sel_in] <= 1'b1;
    end else if (cfg_wr) begin
      case (cfg_addr)
        `PMBP_CFG_EXT_LOCK: ext_lock_q[3:0] <= ext_lock_q[3:0] & (cfg_data[3:0] | ~impl_mask[3:0]);
        `PMBP_CFG_BOOT_EE_EXT: begin
          ee_ext_lock_q <= ee_ext_lock_q & cfg_data[`PMBP_BIT_EE_EXT];
          ext_lock_q[4] <= ext_lock_q[4] & cfg_data[`PMBP_BIT_BOOT_EXT];
        end
        `PMBP_CFG_TW_LOCK: tw_lock_q[3:0] <= tw_lock_q[3:0] & (cfg_data[3:0] | ~impl_mask[3:0]);
        `PMBP_CFG_BOOT_EE_CW: begin
          ee_wr_lock_q <= ee_wr_lock_q & cfg_data[`PMBP_BIT_EE_WR];
          tw_lock_q[4] <= tw_lock_q[4] & cfg_data[`PMBP_BIT_BOOT_TW];
          cfg_wr_lock_q <= cfg_wr_lock_q & (cfg_data[`PMBP_BIT_CFG_WR] | ~cfg_wr_from_prog);
        end
        `PMBP_CFG_XR_LOCK: xr_lock_q[3:0] <= xr_lock_q[3:0] & (cfg_data[3:0] | ~impl_mask[3:0]);
        `PMBP_CFG_BOOT_XR: xr_lock_q[4] <= xr_lock_q[4] & cfg_data[`PMBP_BIT_BOOT_XR];
        default: ext_lock_q <= ext_lock_q;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // id bytes
  // ----------------------------------------------------------------------
  // id bytes are not under block locks; one write per byte per cycle, programmer first
  genvar gi;
  generate
    for (gi = 0; gi < `PMBP_ID_COUNT; gi = gi + 1) begin : g_id
      always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          id_mem_q[gi] <= `PMBP_ERASED;
        end else if (prog_wr_ok && prog_is_id && (prog_addr_in[2:0] == gi)) begin
          id_mem_q[gi] <= prog_wdata_in;
        end else if (core_wr_ok && core_is_id && (core_addr_in[2:0] == gi)) begin
          id_mem_q[gi] <= core_wdata_in;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  // the programmer wins the array write port if both strobe at once
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      core_rdata_out <= 8'h00;
      core_rvalid_out <= 1'b0;
      core_ee_rd_ok_out <= 1'b0;
      prog_rdata_out <= 8'h00;
      prog_rvalid_out <= 1'b0;
      prog_refused_out <= 1'b0;
      mem_wr_out <= 1'b0;
      mem_addr_out <= {`PMBP_ADDR_W{1'b0}};
      mem_wdata_out <= 8'h00;
      core_denied_out <= 1'b0;
    end else begin
      core_rvalid_out <= core_rd_in;
      core_rdata_out <= core_rd_in ? core_rd_d : 8'h00;
      core_ee_rd_ok_out <= core_ee_rd_in;
      prog_rvalid_out <= prog_rd_in;
      prog_rdata_out <= prog_rd_in ? prog_rd_d : 8'h00;
      prog_refused_out <= prog_rd_deny || prog_wr_deny;
      core_denied_out <= (core_rd_in && core_xr_deny) ||
        (core_wr_in && (core_tw_deny || core_cfg_deny));
      // a core write that meets an accepted programmer array write in one cycle is lost, not queued
      mem_wr_out <= (prog_wr_ok && prg_impl) || (core_wr_ok && tgt_impl);
      if (prog_wr_ok && prg_impl) begin
        mem_addr_out <= prog_addr_in;
        mem_wdata_out <= prog_wdata_in;
      end else if (core_wr_ok && tgt_impl) begin
        mem_addr_out <= core_addr_in;
        mem_wdata_out <= core_wdata_in;
      end
    end
  end

endmodule // pmbp_protect

//--- test/pmbp_monitor.sv
// Purpose: port-level checks for the block protection logic
// Assumes: one clock, async active-low reset, strobes answered one cycle later
// Notes: sees only the top ports; attached by bind from the bench top
`timescale 1ns/1ns
`include "pmbp_defines.vh"
module pmbp_monitor (
  input wire clk_in,
  input wire arst_n_in,
  input wire core_rd_in,
  input wire core_wr_in,
  input wire [`PMBP_ADDR_W-1:0] core_addr_in,
  input wire [7:0] core_wdata_in,
  input wire core_ee_rd_in,
  input wire prog_rd_in,
  input wire prog_wr_in,
  input wire [7:0] core_rdata_out,
  input wire core_rvalid_out,
  input wire core_ee_rd_ok_out,
  input wire [7:0] prog_rdata_out,
  input wire prog_refused_out,
  input wire mem_wr_out,
  input wire [`PMBP_ADDR_W-1:0] mem_addr_out,
  input wire [7:0] mem_wdata_out,
  input wire core_denied_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_core_read_answer: assert property (core_rvalid_out == $past(core_rd_in))
    else $error("core read answer missing or spurious");
  a_denied_reads_zero: assert property (core_rvalid_out && core_denied_out |-> core_rdata_out == 8'h00)
    else $error("denied core read returned data");
  a_write_has_cause: assert property (mem_wr_out |-> $past(core_wr_in || prog_wr_in))
    else $error("array write without request");
  a_core_write_path: assert property ($past(core_wr_in) && !$past(prog_wr_in) && mem_wr_out
    |-> mem_addr_out == $past(core_addr_in) && mem_wdata_out == $past(core_wdata_in))
    else $error("core write reached wrong address or data");
  a_ee_read_grant: assert property (core_ee_rd_in |=> core_ee_rd_ok_out)
    else $error("core eeprom read not granted");
  a_refusal_no_data: assert property (prog_refused_out |-> prog_rdata_out == 8'h00)
    else $error("refused programmer access leaked data");
  a_refusal_cause: assert property (prog_refused_out |-> $past(prog_rd_in || prog_wr_in))
    else $error("refusal without programmer request");
  a_refused_no_write: assert property (prog_refused_out |-> !mem_wr_out)
    else $error("refused programmer write reached array");
  a_id_not_denied: assert property (core_rd_in && core_addr_in >= `PMBP_ID_FIRST
    && core_addr_in <= `PMBP_ID_LAST |=> !core_denied_out)
    else $error("id byte read denied");
  c_denied: cover property (core_rvalid_out && core_denied_out);
  c_refused: cover property (prog_refused_out);
  c_array_write: cover property (mem_wr_out);
endmodule // pmbp_monitor

//--- test/pmbp_mem_model.sv
// Purpose: program memory array seen by the protection block
// Assumes: combinational read, address taken from the programmer while it reads
// Notes: contents are a fixed address pattern; writes are judged at the strobes
`timescale 1ns/1ns
`include "pmbp_defines.vh"
module pmbp_mem_model (
  input wire [`PMBP_ADDR_W-1:0] core_addr_in,
  input wire [`PMBP_ADDR_W-1:0] prog_addr_in,
  input wire prog_rd_in,
  output wire [7:0] mem_rdata_out
);
  // ----------------------------------------------------------------------
  // array read
  // ----------------------------------------------------------------------
  wire [`PMBP_ADDR_W-1:0] sel_addr = prog_rd_in ? prog_addr_in : core_addr_in;
  // a pattern per address, so a stale or zeroed byte never passes for real data
  assign mem_rdata_out = sel_addr[7:0] ^ sel_addr[15:8] ^ 8'h3c;
endmodule // pmbp_mem_model

//--- test/pmbp_protect_tb_top.sv
// Purpose: directed bench for the block protection logic
// Assumes: inputs change 1 ns after the rising edge; answers sampled one cycle later
// Notes: each strobe is followed by an idle cycle so no driver assigns twice per step
`timescale 1ns/1ns
`include "pmbp_defines.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module pmbp_protect_tb_top;
  logic clk_in = 0, arst_n_in = 0, core_rd_in = 0, core_wr_in = 0, core_ee_rd_in = 0;
  logic [21:0] core_addr_in = 0, core_pc_in = 0, prog_addr_in = 0;
  logic [7:0] core_wdata_in = 0, prog_wdata_in = 0, mem_rdata_in, core_rdata_out, prog_rdata_out, mem_wdata_out;
  logic prog_rd_in = 0, prog_wr_in = 0, prog_ee_in = 0, prog_chip_erase_in = 0, prog_blk_erase_in = 0;
  logic [2:0] prog_blk_sel_in = 0;
  logic core_rvalid_out, core_ee_rd_ok_out, prog_rvalid_out, prog_refused_out, mem_wr_out, core_denied_out;
  logic [21:0] mem_addr_out;
  int mismatches = 0, n_checks = 0;
  pmbp_protect #(.HAS_TOP_BLOCK(1), .DEVID_LO(8'h5a), .DEVID_HI(8'ha5)) pmbp_protect_i (.clk_in, .arst_n_in,
    .core_rd_in, .core_wr_in, .core_addr_in, .core_pc_in,
    .core_wdata_in, .mem_rdata_in, .core_ee_rd_in, .core_rdata_out, .core_rvalid_out, .core_ee_rd_ok_out,
    .prog_rd_in, .prog_wr_in, .prog_ee_in, .prog_addr_in, .prog_wdata_in, .prog_chip_erase_in,
    .prog_blk_erase_in, .prog_blk_sel_in, .prog_rdata_out, .prog_rvalid_out, .prog_refused_out,
    .mem_wr_out, .mem_addr_out, .mem_wdata_out, .core_denied_out);
  pmbp_mem_model pmbp_mem_model_i (.core_addr_in, .prog_addr_in, .prog_rd_in, .mem_rdata_out(mem_rdata_in));
  // ----------------------------------------------------------------------
  // clock, helpers and access tasks
  // ----------------------------------------------------------------------
  initial begin
    forever #5 clk_in = ~clk_in;
  end
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  function automatic [7:0] pat(input [21:0] a);
    pat = a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  // core table read: answer and denial looked at in the one cycle they stand
  task automatic crd(input [21:0] a, input [21:0] pc, input [7:0] d, input den);
    core_addr_in = a;
    core_pc_in = pc;
    core_rd_in = 1;
    step();
    core_rd_in = 0;
    `CHK(core_rdata_out, d)
    `CHK(core_denied_out, den)
    step();
  endtask
  // core table write; chk=0 for config and id bytes, whose array strobe is not ours to judge
  task automatic cwr(input [21:0] a, input [7:0] d, input chk, input w);
    core_addr_in = a;
    core_pc_in = 22'h000000;
    core_wdata_in = d;
    core_wr_in = 1;
    step();
    core_wr_in = 0;
    if (chk) begin
      `CHK(mem_wr_out, w)
      `CHK(core_denied_out, !w)
      if (w) begin
        `CHK(mem_addr_out, a)
        `CHK(mem_wdata_out, d)
      end
    end
    step();
  endtask
  // programmer read or write
  task automatic pacc(input wr, input ee, input [21:0] a, input [7:0] d, input rf, input [7:0] rd);
    prog_addr_in = a;
    prog_ee_in = ee;
    prog_wdata_in = d;
    if (wr) prog_wr_in = 1;
    else prog_rd_in = 1;
    step();
    prog_wr_in = 0;
    prog_rd_in = 0;
    `CHK(prog_refused_out, rf)
    `CHK(prog_rvalid_out, !wr)
    if (!wr) `CHK(prog_rdata_out, rd)
    step();
  endtask
  task automatic ers(input chip, input [2:0] sel);
    prog_blk_sel_in = sel;
    if (chip) prog_chip_erase_in = 1;
    else prog_blk_erase_in = 1;
    step();
    prog_chip_erase_in = 0;
    prog_blk_erase_in = 0;
    step();
  endtask
  // erased protection bytes, unused bits reading zero
  task automatic cfgchk();
    logic [7:0] ev [6] = '{8'h0f, 8'hc0, 8'h0f, 8'he0, 8'h0f, 8'h40};
    for (int i = 0; i < 6; i++) crd(22'(`PMBP_CFG_FIRST + i), 22'h000000, ev[i], 1'b0);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_in);
    #1 arst_n_in = 1;
    step();
    ers(1'b1, 3'd0);
    cfgchk();
    crd(`PMBP_DEVID_LO, 22'h000000, 8'h5a, 1'b0);
    crd(`PMBP_DEVID_HI, 22'h000000, 8'ha5, 1'b0);
    $display("test reset_map done");
    cwr(`PMBP_CFG_XR_LOCK, 8'h0e, 1'b0, 1'b0);
    crd(22'h000800, 22'h004000, 8'h00, 1'b1);
    crd(22'h003fff, 22'h0007ff, 8'h00, 1'b1);
    crd(22'h003fff, 22'h000800, pat(22'h003fff), 1'b0);
    crd(22'h0007ff, 22'h004000, pat(22'h0007ff), 1'b0);
    cwr(`PMBP_CFG_XR_LOCK, 8'hff, 1'b0, 1'b0);
    crd(`PMBP_CFG_XR_LOCK, 22'h000000, 8'h0e, 1'b0);
    $display("test cross_read done");
    cwr(`PMBP_CFG_TW_LOCK, 8'h0b, 1'b0, 1'b0);
    cwr(22'h008000, 8'h96, 1'b1, 1'b0);
    cwr(22'h007fff, 8'h69, 1'b1, 1'b1);
    crd(`PMBP_ID_FIRST, 22'h000000, 8'hff, 1'b0);
    cwr(`PMBP_ID_LAST, 8'h5c, 1'b0, 1'b0);
    crd(`PMBP_ID_LAST, 22'h000000, 8'h5c, 1'b0);
    $display("test table_write done");
    pacc(1'b1, 1'b0, `PMBP_CFG_EXT_LOCK, 8'h0d, 1'b0, 8'h00);
    pacc(1'b0, 1'b0, 22'h004000, 8'h00, 1'b1, 8'h00);
    pacc(1'b1, 1'b0, 22'h004100, 8'h11, 1'b1, 8'h00);
    pacc(1'b0, 1'b0, 22'h008000, 8'h00, 1'b0, pat(22'h008000));
    crd(22'h004000, 22'h004000, pat(22'h004000), 1'b0);
    crd(`PMBP_ID_LAST, 22'h004000, 8'h5c, 1'b0);
    pacc(1'b1, 1'b0, `PMBP_CFG_BOOT_EE_CW, 8'h7f, 1'b0, 8'h00);
    pacc(1'b1, 1'b1, 22'h000010, 8'h22, 1'b1, 8'h00);
    pacc(1'b0, 1'b1, 22'h000010, 8'h00, 1'b0, 8'h00);
    pacc(1'b1, 1'b0, `PMBP_CFG_BOOT_EE_EXT, 8'h7f, 1'b0, 8'h00);
    pacc(1'b0, 1'b1, 22'h000010, 8'h00, 1'b1, 8'h00);
    core_ee_rd_in = 1;
    step();
    core_ee_rd_in = 0;
    `CHK(core_ee_rd_ok_out, 1'b1)
    step();
    $display("test programmer done");
    cwr(`PMBP_CFG_BOOT_EE_CW, 8'hdf, 1'b0, 1'b0);
    crd(`PMBP_CFG_BOOT_EE_CW, 22'h000000, 8'h60, 1'b0);
    pacc(1'b1, 1'b0, `PMBP_CFG_BOOT_EE_CW, 8'hdf, 1'b0, 8'h00);
    crd(`PMBP_CFG_BOOT_EE_CW, 22'h000000, 8'h40, 1'b0);
    cwr(`PMBP_CFG_XR_LOCK, 8'h00, 1'b0, 1'b0);
    crd(`PMBP_CFG_XR_LOCK, 22'h000000, 8'h0e, 1'b0);
    $display("test config_lock done");
    ers(1'b0, 3'd1);
    pacc(1'b0, 1'b0, 22'h004000, 8'h00, 1'b0, pat(22'h004000));
    ers(1'b1, 3'd0);
    cfgchk();
    cwr(`PMBP_CFG_TW_LOCK, 8'h00, 1'b0, 1'b0);
    arst_n_in = 0;
    step();
    arst_n_in = 1;
    step();
    crd(`PMBP_CFG_TW_LOCK, 22'h000000, 8'h00, 1'b0);
    cwr(22'h004000, 8'h33, 1'b1, 1'b0);
    ers(1'b1, 3'd0);
    cfgchk();
    $display("test erase_reset done");
    wrap_up();
  end
  // watchdog: the tests need well under 2000 cycles
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
endmodule // pmbp_protect_tb_top
bind pmbp_protect pmbp_monitor pmbp_monitor_i (.clk_in, .arst_n_in, .core_rd_in, .core_wr_in, .core_addr_in,
  .core_wdata_in, .core_ee_rd_in, .prog_rd_in, .prog_wr_in, .core_rdata_out, .core_rvalid_out,
  .core_ee_rd_ok_out, .prog_rdata_out, .prog_refused_out, .mem_wr_out, .mem_addr_out, .mem_wdata_out,
  .core_denied_out);
